/* hdl/pbc4_cfg.svh */
// Purpose: Constants of the presettable 4-bit counter: widths, offsets, fields, resets.
// Assumes: Included by the package and by every design file that needs a value.
// Notes:   Definitions only.
`ifndef PBC4_CFG_SVH
`define PBC4_CFG_SVH

`define PBC4_CNT_W          4
`define PBC4_ADDR_W         4
`define PBC4_DATA_W         32

`define PBC4_OFS_CTRL       4'h0
`define PBC4_OFS_STAT       4'h4

`define PBC4_CTRL_CHAIN_BIT 0
`define PBC4_STAT_CNT_LSB   0
`define PBC4_STAT_MODE_LSB  4

`define PBC4_CTRL_RST       1'b0
`define PBC4_CNT_RST        4'h0
`define PBC4_EDGE_RST       1'b0

`define PBC4_MODE_CLEAR     2'h0
`define PBC4_MODE_LOAD      2'h1
`define PBC4_MODE_COUNT     2'h3

`endif

/* hdl/pbc4_counter.sv */
// Purpose: Presettable 4-bit binary ripple counter with clear, load and two stage clocks.
// Assumes: All pins are synchronous to clk_i; the pin clocks are much slower than clk_i.
// Notes:   Outputs settle one clk_i cycle after the cause, since every output is a flop.
//
// Behaviour
// - Four-bit counter stepping through the plain binary sequence.
// - Counting changes outputs only on a high-to-low clock input transition.
// - Clear low forces all outputs to zero regardless of either clock.
// - Controller drives load low with data; device takes data as its count.
// - While load is low, outputs follow data without waiting for a clock edge.
// - Stages clocked separately; first stage output clocks the next for full count.
`timescale 1ns/100ps
`include "pbc4_cfg.svh"

module pbc4_counter (
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         clr_n_i,
    input  wire logic                         load_n_i,
    input  wire logic                         stage0_clk_i,
    input  wire logic                         stage1_clk_i,
    input  wire pbc4_pkg::pbc4_cnt_t          data_i,
    input  wire logic [`PBC4_ADDR_W-1:0]      addr_i,
    input  wire logic [`PBC4_DATA_W-1:0]      wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [`PBC4_DATA_W-1:0]      rdata_o,
    output logic                              count_bit0_o,
    output logic                              count_bit1_o,
    output logic                              count_bit2_o,
    output logic                              count_bit3_o
);
    import pbc4_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    logic       fall0;
    logic       fall1;
    logic       upper_tick;
    pbc4_cnt_t  count_q;
    pbc4_cnt_t  count_d;
    pbc4_cnt_t  step_d;
    pbc4_mode_t mode_q;
    pbc4_mode_t mode_d;

    pbc4_reg_if rif ();

    pbc4_fall u_fall0 (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .lvl_i  (stage0_clk_i),
        .fall_o (fall0)
    );

    pbc4_fall u_fall1 (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .lvl_i  (stage1_clk_i),
        .fall_o (fall1)
    );

    pbc4_regs u_regs (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i),
        .wr_i    (wr_i),
        .rd_i    (rd_i),
        .rdata_o (rdata_o),
        .rif     (rif)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Upper three stages form one ripple chain; in a sampled design the carry settles
    // within the same clk_i cycle, so the chain reduces to a 3-bit increment.
    function automatic logic [2:0] upper_inc(input logic [2:0] v);
        upper_inc = v + 3'h1;
    endfunction

    // Internal chaining mirrors the external wire from stage 0 output to stage 1 clock.
    // Stage 0 output falls exactly when it toggles from one. The external wire costs one
    // clk_i cycle of extra ripple delay; the internal path costs none.
    assign upper_tick = rif.chain_en ? (fall0 && count_q[0]) : fall1;

    always_comb begin
        step_d = count_q;
        if (fall0) begin
            step_d[0] = ~count_q[0];
        end
        if (upper_tick) begin
            step_d[3:1] = upper_inc(count_q[3:1]);
        end
    end

    // Clear is checked first so that it overrides a simultaneous load.
    always_comb begin
        if (!clr_n_i) begin
            mode_d = PBC4_CLEAR;
        end else if (!load_n_i) begin
            mode_d = PBC4_LOAD;
        end else begin
            mode_d = PBC4_COUNT;
        end
    end

    always_comb begin
        case (mode_d)
            PBC4_CLEAR: begin
                count_d = `PBC4_CNT_RST;
            end
            PBC4_LOAD: begin
                count_d = data_i;
            end
            PBC4_COUNT: begin
                count_d = step_d;
            end
            default: begin
                count_d = `PBC4_CNT_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_q <= `PBC4_CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= PBC4_CLEAR;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign rif.count    = count_q;
    assign rif.mode     = mode_q;
    assign count_bit0_o = count_q[0];
    assign count_bit1_o = count_q[1];
    assign count_bit2_o = count_q[2];
    assign count_bit3_o = count_q[3];

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_counting;
        clr_n_i && load_n_i;
    endsequence

    sequence s_loading;
        clr_n_i && !load_n_i;
    endsequence

    sequence s_load_held;
        s_loading ##1 s_loading;
    endsequence

    property p_full_step;
        s_counting ##0 (rif.chain_en && fall0)
            |=> count_q == pbc4_cnt_t'($past(count_q) + 4'h1);
    endproperty
    a_full_step: assert property (p_full_step)
        else $error("Chained count did not advance by one.");

    property p_no_edge_hold;
        s_counting ##0 (!fall0 && !(fall1 && !rif.chain_en)) |=> $stable(count_q);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold)
        else $error("Count changed without a falling clock input.");

    property p_rise_hold;
        s_counting ##0 ($rose(stage0_clk_i) && !fall1) |=> $stable(count_q);
    endproperty
    a_rise_hold: assert property (p_rise_hold)
        else $error("Count changed on a rising clock input.");

    property p_clear;
        !clr_n_i |=> count_q == `PBC4_CNT_RST && mode_q == PBC4_CLEAR;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Clear did not force the count to zero.");

    property p_load;
        s_loading |=> count_q == $past(data_i) && mode_q == PBC4_LOAD;
    endproperty
    a_load: assert property (p_load)
        else $error("Load did not take the data inputs.");

    property p_follow;
        s_load_held ##0 $changed(data_i) |=> count_q == $past(data_i);
    endproperty
    a_follow: assert property (p_follow)
        else $error("Outputs did not follow data while loading.");

    property p_clear_wins;
        (!clr_n_i && !load_n_i) [*2] |=> count_q == `PBC4_CNT_RST;
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("Load overrode clear.");

    property p_ripple_link;
        s_counting ##0 (rif.chain_en && fall0 && count_q[0])
            |=> count_q[3:1] == 3'($past(count_q[3:1]) + 3'h1) && !count_q[0];
    endproperty
    a_ripple_link: assert property (p_ripple_link)
        else $error("Stage 0 fall did not clock the upper stages.");

    property p_split_stage;
        s_counting ##0 (!rif.chain_en && fall1 && !fall0)
            |=> count_q[0] == $past(count_q[0])
                && count_q[3:1] == 3'($past(count_q[3:1]) + 3'h1);
    endproperty
    a_split_stage: assert property (p_split_stage)
        else $error("Upper stages did not step on their own clock.");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin-level views: a broken edge detector cannot hide behind its own fall pulse here.
    // They see the raw levels, so the answer lands one cycle after the low level shows.
    sequence s_pin0_fall;
        (stage0_clk_i && clr_n_i && load_n_i) ##1 (!stage0_clk_i && clr_n_i && load_n_i);
    endsequence

    sequence s_pin1_fall;
        (stage1_clk_i && clr_n_i && load_n_i) ##1 (!stage1_clk_i && clr_n_i && load_n_i);
    endsequence

    property p_pin_toggle;
        s_pin0_fall |=> count_q[0] != $past(count_q[0]);
    endproperty
    a_pin_toggle: assert property (p_pin_toggle)
        else $error("Stage 0 pin fall did not toggle bit 0.");

    property p_pin_upper;
        s_pin1_fall ##0 !rif.chain_en
            |=> count_q[3:1] == 3'($past(count_q[3:1]) + 3'h1);
    endproperty
    a_pin_upper: assert property (p_pin_upper)
        else $error("Stage 1 pin fall did not step the upper stages.");

    property p_bit0_toggle;
        s_counting ##0 fall0 |=> count_q[0] != $past(count_q[0]);
    endproperty
    a_bit0_toggle: assert property (p_bit0_toggle)
        else $error("Stage 0 fall did not toggle bit 0.");

    property p_fall_once;
        fall0 |=> !fall0;
    endproperty
    a_fall_once: assert property (p_fall_once)
        else $error("A stage 0 fall was reported twice.");

    property p_upper_hold;
        s_counting ##0 (rif.chain_en && fall0 && !count_q[0])
            |=> count_q[3:1] == $past(count_q[3:1]);
    endproperty
    a_upper_hold: assert property (p_upper_hold)
        else $error("Upper stages moved while bit 0 rose.");

    property p_split_bit0;
        s_counting ##0 (!rif.chain_en && fall0 && !fall1)
            |=> count_q[3:1] == $past(count_q[3:1]);
    endproperty
    a_split_bit0: assert property (p_split_bit0)
        else $error("Bit 0 carried into the upper stages while unchained.");

    property p_wrap;
        s_counting ##0 (rif.chain_en && fall0 && count_q == 4'hF)
            |=> count_q == `PBC4_CNT_RST;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Full count did not wrap to zero.");

    property p_mode_count;
        s_counting |=> mode_q == PBC4_COUNT;
    endproperty
    a_mode_count: assert property (p_mode_count)
        else $error("Mode did not return to counting.");

    property p_clear_mode;
        (!clr_n_i && !load_n_i) |=> mode_q == PBC4_CLEAR;
    endproperty
    a_clear_mode: assert property (p_clear_mode)
        else $error("Load mode shown while clear was low.");

    property p_clear_fall;
        !clr_n_i ##0 (fall0 || fall1) |=> count_q == `PBC4_CNT_RST;
    endproperty
    a_clear_fall: assert property (p_clear_fall)
        else $error("A clock fall disturbed a clear.");

    property p_load_mute;
        s_loading ##0 (fall0 || fall1) |=> count_q == $past(data_i);
    endproperty
    a_load_mute: assert property (p_load_mute)
        else $error("A clock fall disturbed a load.");

    property p_keep_load;
        s_loading ##1 s_counting ##0 (!fall0 && !fall1) |=> count_q == $past(data_i, 2);
    endproperty
    a_keep_load: assert property (p_keep_load)
        else $error("Loaded value was not kept after load ended.");

endmodule

/* hdl/pbc4_fall.sv */
// Purpose: Falling-edge detector for a counter clock input.
// Assumes: The input is synchronous to clk_i.
// Notes:   The pulse is one cycle, in the cycle where the low level is first seen.
`timescale 1ns/100ps
`include "pbc4_cfg.svh"

module pbc4_fall (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic lvl_i,
    output logic      fall_o
);
    logic lvl_q;

    // Resetting the history low means a pin already low at release gives no false edge.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_q <= `PBC4_EDGE_RST;
        end else begin
            lvl_q <= lvl_i;
        end
    end

    assign fall_o = lvl_q & ~lvl_i;
endmodule

/* hdl/pbc4_pkg.sv */
// Purpose: Types shared by the counter, its register port and its carrier interface.
// Assumes: The constants header is on the include path.
// Notes:   Mode codes are Gray along clear, load, count.
`include "pbc4_cfg.svh"

package pbc4_pkg;

    typedef enum logic [1:0] {
        PBC4_CLEAR = `PBC4_MODE_CLEAR,
        PBC4_LOAD  = `PBC4_MODE_LOAD,
        PBC4_COUNT = `PBC4_MODE_COUNT
    } pbc4_mode_t;

    typedef logic [`PBC4_CNT_W-1:0] pbc4_cnt_t;

endpackage

/* hdl/pbc4_reg_if.sv */
// Purpose: Carrier between the counter core and its register port.
// Assumes: One clock domain.
// Notes:   The register side steers the chain option and reads back state.
`timescale 1ns/100ps

interface pbc4_reg_if;
    import pbc4_pkg::*;

    logic       chain_en;
    pbc4_cnt_t  count;
    pbc4_mode_t mode;

    modport regs (output chain_en, input count, input mode);
    modport core (input chain_en, output count, output mode);
endinterface

/* hdl/pbc4_regs.sv */
// Purpose: Register port of the counter: control word and status word.
// Assumes: Strobes are one cycle and never together; reads answer in the next cycle.
// Notes:   Unmapped reads return zero; unmapped writes are dropped.
`timescale 1ns/100ps
`include "pbc4_cfg.svh"

module pbc4_regs (
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic [`PBC4_ADDR_W-1:0] addr_i,
    input  wire logic [`PBC4_DATA_W-1:0] wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [`PBC4_DATA_W-1:0] rdata_o,
    pbc4_reg_if.regs                     rif
);
    import pbc4_pkg::*;

    logic                    chain_q;
    logic [`PBC4_DATA_W-1:0] rdata_q;
    logic [`PBC4_DATA_W-1:0] rdata_d;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chain_q <= `PBC4_CTRL_RST;
        end else if (wr_i && addr_i == `PBC4_OFS_CTRL) begin
            chain_q <= wdata_i[`PBC4_CTRL_CHAIN_BIT];
        end
    end

    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                `PBC4_OFS_CTRL: begin
                    rdata_d[`PBC4_CTRL_CHAIN_BIT] = chain_q;
                end
                `PBC4_OFS_STAT: begin
                    rdata_d[`PBC4_STAT_CNT_LSB +: `PBC4_CNT_W] = rif.count;
                    rdata_d[`PBC4_STAT_MODE_LSB +: 2]          = rif.mode;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rif.chain_en = chain_q;
    assign rdata_o      = rdata_q;
endmodule

/* verification/pbc4_counter_tb_top.sv */
// Purpose: Self-checking bench of the counter against an integer model.
// Assumes: Pins and strobes change by non-blocking assignment after a rising edge.
// Notes:   The external ripple wiring is switched only while bit0 is low.
`timescale 1ns/100ps
`include "pbc4_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module pbc4_counter_tb_top;
    import pbc4_pkg::*;

    logic        clk_i, nrst_i, clr_n, load_n, wr, rd, go0, go1, wire_en;
    pbc4_cnt_t   data;
    logic [3:0]  addr;
    logic [31:0] wdata, rv;
    wire  logic [31:0] rdata;
    wire  logic  b0, b1, b2, b3, s0, s1, busy;
    wire  pbc4_cnt_t cnt = {b3, b2, b1, b0};
    int          failures, comparisons, seed, ex, chain, i;

    pbc4_counter DUT (.clk_i(clk_i), .nrst_i(nrst_i), .clr_n_i(clr_n), .load_n_i(load_n),
        .stage0_clk_i(s0), .stage1_clk_i(s1), .data_i(data), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .count_bit0_o(b0),
        .count_bit1_o(b1), .count_bit2_o(b2), .count_bit3_o(b3));
    pbc4_ctl_model ctl (.clk_i(clk_i), .nrst_i(nrst_i), .go0_i(go0), .go1_i(go1),
        .wire_i(wire_en), .bit0_i(b0), .stage0_clk_o(s0), .stage1_clk_o(s1), .busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, then return to zero.
    task rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a; rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk_i);
        #1 `CHK("rdata idle", 32'h0, rdata)
    endtask

    task pins(input logic c, input logic l, input pbc4_cnt_t d);
        @(posedge clk_i);
        clr_n <= c; load_n <= l; data <= d;
        if (!c) ex = 0;
        else if (!l) ex = d;
        repeat (2) @(posedge clk_i);
        #1 `CHK("count pins", pbc4_cnt_t'(ex), cnt)
        rd_reg(4'h4, rv);
        `CHK("status count", pbc4_cnt_t'(ex), rv[3:0])
        `CHK("status mode", (!c ? 2'h0 : (!l ? 2'h1 : 2'h3)), rv[5:4])
    endtask

    task pulse(input int st, input int settle);
        int k;
        @(posedge clk_i);
        if (st == 1) go1 <= 1'b1;
        else go0 <= 1'b1;
        @(posedge clk_i);
        go0 <= 1'b0; go1 <= 1'b0;
        #1 `CHK("count while clock high", pbc4_cnt_t'(ex), cnt)
        k = 0;
        while (busy !== 1'b0 && k < 20) begin
            @(posedge clk_i);
            #1 k++;
        end
        if (k >= 20) begin
            failures++;
            close_out;
        end
        if (load_n === 1'b1 && clr_n === 1'b1) begin
            if (st == 1 && chain == 0) ex = ((((ex >> 1) + 1) & 7) << 1) | (ex & 1);
            else if (st == 0 && (chain == 1 || wire_en)) ex = (ex + 1) & 15;
            else if (st == 0) ex = ex ^ 1;
        end
        repeat (settle) @(posedge clk_i);
        #1 `CHK("count after fall", pbc4_cnt_t'(ex), cnt)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i = 1'b0; clr_n = 1'b1; load_n = 1'b1; data = 4'h0; addr = 4'h0;
        wdata = 32'h0; wr = 1'b0; rd = 1'b0; go0 = 1'b0; go1 = 1'b0; wire_en = 1'b0;
        failures = 0; comparisons = 0; seed = 29; ex = 0; chain = 0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        #1 `CHK("count after reset", 4'h0, cnt)
        rd_reg(4'h0, rv);
        `CHK("ctrl reset", 32'h0, rv)
        wr_reg(4'h0, 32'h1);
        chain = 1;
        wr_reg(4'h8, 32'h0);
        rd_reg(4'h0, rv);
        `CHK("ctrl chain", 32'h1, rv)
        rd_reg(4'h8, rv);
        `CHK("unmapped read", 32'h0, rv)
        for (i = 0; i < 18; i++) pulse(0, 1);
        pulse(1, 1);
        pins(1'b0, 1'b1, 4'hF);
        pulse(0, 1);
        pins(1'b0, 1'b0, pbc4_cnt_t'($random(seed)));
        pins(1'b1, 1'b0, pbc4_cnt_t'($random(seed)));
        pins(1'b1, 1'b0, pbc4_cnt_t'($random(seed)));
        pulse(0, 1);
        pins(1'b1, 1'b1, 4'h0);
        pulse(0, 1);
        wr_reg(4'h0, 32'h0);
        chain = 0;
        for (i = 0; i < 24; i++) pulse($random(seed) & 1, 1);
        pins(1'b0, 1'b1, 4'h0);
        @(posedge clk_i);
        wire_en <= 1'b1;
        pins(1'b1, 1'b1, 4'h0);
        // The wired link adds one cycle, so the settle time is longer here.
        for (i = 0; i < 17; i++) pulse(0, 3);
        pins(1'b0, 1'b1, 4'h0);
        close_out;
    end

    initial begin
        #300000;
        failures++;
        close_out;
    end
endmodule

/* verification/pbc4_ctl_model.sv */
// Purpose: Control logic beside the counter: makes stage clock pulses on request.
// Assumes: One clock; requests are one-cycle pulses while idle.
// Notes:   Stage 0 clock, and stage 1 clock while unwired, rest low between pulses, as real drive logic parks them.
`timescale 1ns/100ps

module pbc4_ctl_model (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic go0_i,
    input  wire logic go1_i,
    input  wire logic wire_i,
    input  wire logic bit0_i,
    output logic      stage0_clk_o,
    output logic      stage1_clk_o,
    output logic      busy_o
);
    logic [2:0] ph_q;
    logic       sel_q;
    logic       hi;

    ////////////////////////////////////////////////////////////////////////
    // Two cycles high, two low, so each level is seen by at least one edge.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_q  <= 3'h0;
            sel_q <= 1'b0;
        end else if (ph_q == 3'h0 && (go0_i || go1_i)) begin
            ph_q  <= 3'h1;
            sel_q <= go1_i;
        end else if (ph_q != 3'h0) begin
            ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        end
    end

    assign hi           = (ph_q == 3'h1) || (ph_q == 3'h2);
    assign busy_o       = (ph_q != 3'h0);
    assign stage0_clk_o = hi && !sel_q;
    // Wiring the first stage output to the next stage clock forms the ripple chain.
    assign stage1_clk_o = wire_i ? bit0_i : (hi && sel_q);
endmodule
